// ===== hw/sdarb_defines.vh
// register map, field positions, reset values and timing counts of the sdram arbiter block
`ifndef SDARB_DEFINES_VH
`define SDARB_DEFINES_VH
`define SDARB_ADDR_W 8
`define SDARB_OFS_ARB_CFG 8'h08
`define SDARB_OFS_ILL_ADDR 8'h10
`define SDARB_OFS_ILL_ATTR 8'h14
`define SDARB_OFS_PWR_SAVE 8'h1c
`define SDARB_OFS_SDRAM_CTL 8'h04
`define SDARB_CFG_RR_BIT 30
`define SDARB_CFG_POST_BIT 29
`define SDARB_CFG_PRE_BIT 28
`define SDARB_CFG_WAIT_HI 15
`define SDARB_CFG_WAIT_LO 8
`define SDARB_CFG_HOLD_HI 3
`define SDARB_CFG_HOLD_LO 0
`define SDARB_ATTR_IRQ_BIT 31
`define SDARB_ATTR_WR_BIT 30
`define SDARB_ATTR_LANE_HI 19
`define SDARB_ATTR_LANE_LO 16
`define SDARB_ATTR_IID_HI 10
`define SDARB_ATTR_IID_LO 8
`define SDARB_ATTR_LEN_HI 7
`define SDARB_ATTR_LEN_LO 0
`define SDARB_PWR_CNT_HI 31
`define SDARB_PWR_CNT_LO 24
`define SDARB_PWR_TAR_HI 23
`define SDARB_PWR_TAR_LO 0
`define SDARB_CTL_PD_EN_BIT 28
`define SDARB_RST_CFG 32'h0000_0000
`define SDARB_CFG_MASK 32'h7000_ff0f
`define SDARB_RST_TARGET 24'h03_ffff
`define SDARB_IDLE_UNIT 4'h0
`define SDARB_IDLE_UNIT_CYCLES 5'h1_0
`endif

// ===== hw/sdarb_top.v
// sdram arbiter with cpu locking, illegal access capture and idle power saving
`timescale 1ns/1ns
`default_nettype none
`include "sdarb_defines.vh"

module sdarb_top (
  input wire clock,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire [7:0] master_req,
  input wire cpu_cmd_seen,
  input wire sdram_done,
  output reg [7:0] master_grant,
  input wire access_illegal,
  input wire [31:0] access_addr,
  input wire access_is_write,
  input wire [3:0] access_byte_lanes,
  input wire [2:0] access_initiator,
  input wire [7:0] access_size,
  output reg illegal_irq,
  output reg sdram_power_save,
  output reg sdram_powerdown_enable_out
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [31:0] memory_arbiter_config;
reg [31:0] illegal_access_address;
reg illegal_irq_pending;
reg illegal_is_write;
reg [3:0] illegal_byte_lanes;
reg [2:0] illegal_initiator_code;
reg [7:0] illegal_size_bytes;
reg [7:0] self_refresh_entry_count;
reg [23:0] idle_target_count;
reg sdram_powerdown_enable;

wire wr_cfg = reg_write && (reg_addr == `SDARB_OFS_ARB_CFG);
wire wr_addr = reg_write && (reg_addr == `SDARB_OFS_ILL_ADDR);
wire wr_attr = reg_write && (reg_addr == `SDARB_OFS_ILL_ATTR);
wire wr_pwr = reg_write && (reg_addr == `SDARB_OFS_PWR_SAVE);
wire wr_ctl = reg_write && (reg_addr == `SDARB_OFS_SDRAM_CTL);
wire irq_clear = wr_attr && reg_wdata[`SDARB_ATTR_IRQ_BIT];

wire rr_en = memory_arbiter_config[`SDARB_CFG_RR_BIT];
wire [7:0] dma_wait_limit = memory_arbiter_config[`SDARB_CFG_WAIT_HI:`SDARB_CFG_WAIT_LO];
wire [3:0] processor_hold_cycles = memory_arbiter_config[`SDARB_CFG_HOLD_HI:`SDARB_CFG_HOLD_LO];
wire lock_allowed = (dma_wait_limit != 8'h00);
wire pre_en = memory_arbiter_config[`SDARB_CFG_PRE_BIT] && lock_allowed;
wire post_en = memory_arbiter_config[`SDARB_CFG_POST_BIT] && lock_allowed;

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    memory_arbiter_config <= `SDARB_RST_CFG;
    idle_target_count <= `SDARB_RST_TARGET;
    sdram_powerdown_enable <= 1'b0;
  end else begin
    if (wr_cfg) begin
      memory_arbiter_config <= reg_wdata & `SDARB_CFG_MASK;
    end
    if (wr_pwr) begin
      idle_target_count <= reg_wdata[`SDARB_PWR_TAR_HI:`SDARB_PWR_TAR_LO];
    end
    if (wr_ctl) begin
      sdram_powerdown_enable <= reg_wdata[`SDARB_CTL_PD_EN_BIT];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// illegal access capture
// a new illegal access in the clear cycle wins, so no event is lost;
// while pending, later accesses are not captured so the first stays visible
always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    illegal_access_address <= 32'h0000_0000;
    illegal_irq_pending <= 1'b0;
    illegal_is_write <= 1'b0;
    illegal_byte_lanes <= 4'h0;
    illegal_initiator_code <= 3'h0;
    illegal_size_bytes <= 8'h00;
  end else if (access_illegal && (!illegal_irq_pending || irq_clear)) begin
    illegal_access_address <= access_addr;
    illegal_irq_pending <= 1'b1;
    illegal_is_write <= access_is_write;
    illegal_byte_lanes <= access_byte_lanes;
    illegal_initiator_code <= access_initiator;
    illegal_size_bytes <= access_size;
  end else if (irq_clear) begin
    illegal_access_address <= 32'h0000_0000;
    illegal_irq_pending <= 1'b0;
    illegal_is_write <= 1'b0;
    illegal_byte_lanes <= 4'h0;
    illegal_initiator_code <= 3'h0;
    illegal_size_bytes <= 8'h00;
  end else if (wr_addr) begin
    illegal_is_write <= 1'b0;
    illegal_byte_lanes <= 4'h0;
    illegal_initiator_code <= 3'h0;
    illegal_size_bytes <= 8'h00;
  end
end

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    illegal_irq <= 1'b0;
  end else begin
    illegal_irq <= illegal_irq_pending;
  end
end

////////////////////////////////////////////////////////////////////////////////
// arbiter: master 0 is the cpu, masters 1..7 are dma-type
localparam ST_IDLE = 2'h0;
localparam ST_BUSY = 2'h1;
localparam ST_POST = 2'h2;

reg [1:0] state;
reg [2:0] owner;
reg [2:0] last_owner;
reg [3:0] hold_count;
reg [7:0] wait_count;
reg pre_lock;
reg [1:0] next_state;
reg [2:0] pick;
reg pick_valid;
reg [3:0] next_hold_count;
reg [7:0] next_wait_count;
reg next_pre_lock;
integer i;

wire dma_waiting = |master_req[7:1];
wire locked = pre_lock || (state == ST_POST);
wire lock_cancel = locked && dma_waiting && (wait_count >= dma_wait_limit);

// masters past the last owner; the rotating search tries these first
wire [7:0] req_after;
genvar g;
generate
  for (g = 0; g < 8; g = g + 1) begin : gen_after
    localparam [2:0] MASTER_ID = g;
    assign req_after[g] = master_req[g] && (MASTER_ID > last_owner);
  end
endgenerate

always @* begin
  pick = 3'h0;
  pick_valid = 1'b0;
  if (rr_en) begin
    // fall back to the lowest requester when nobody sits past the last owner
    for (i = 7; i >= 0; i = i - 1) begin
      if (master_req[i]) begin
        pick = i[2:0];
        pick_valid = 1'b1;
      end
    end
    for (i = 7; i >= 0; i = i - 1) begin
      if (req_after[i]) begin
        pick = i[2:0];
      end
    end
  end else begin
    for (i = 7; i >= 0; i = i - 1) begin
      if (master_req[i]) begin
        pick = i[2:0];
        pick_valid = 1'b1;
      end
    end
  end
  // a held lock steers the grant to the cpu only
  if (locked && !lock_cancel) begin
    pick = 3'h0;
    pick_valid = master_req[0];
  end
end

always @* begin
  next_state = state;
  case (state)
    ST_IDLE: begin
      if (pick_valid) begin
        next_state = ST_BUSY;
      end
    end
    ST_BUSY: begin
      if (sdram_done) begin
        if (owner == 3'h0 && post_en && processor_hold_cycles != 4'h0) begin
          next_state = ST_POST;
        end else begin
          next_state = ST_IDLE;
        end
      end
    end
    ST_POST: begin
      if (lock_cancel || hold_count == 4'h1) begin
        next_state = ST_IDLE;
      end
      if (master_req[0] && !lock_cancel) begin
        next_state = ST_BUSY;
      end
    end
    default: begin
      next_state = ST_IDLE;
    end
  endcase
end

always @* begin
  next_hold_count = hold_count;
  if (state == ST_BUSY && next_state == ST_POST) begin
    next_hold_count = processor_hold_cycles;
  end else if (state == ST_POST && hold_count != 4'h0) begin
    next_hold_count = hold_count - 4'h1;
  end
end

// pre-lock holds from the cpu command until the cpu is served
always @* begin
  next_pre_lock = pre_lock;
  if (!pre_en || lock_cancel) begin
    next_pre_lock = 1'b0;
  end else if (cpu_cmd_seen) begin
    next_pre_lock = 1'b1;
  end else if (state == ST_BUSY && owner == 3'h0) begin
    next_pre_lock = 1'b0;
  end
end

// the count restarts whenever the lock lapses, so each lock gets the full allowance
always @* begin
  next_wait_count = 8'h00;
  if (locked && dma_waiting && !lock_cancel) begin
    next_wait_count = wait_count + 8'h01;
  end
end

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    state <= ST_IDLE;
    owner <= 3'h0;
    last_owner <= 3'h0;
    hold_count <= 4'h0;
    wait_count <= 8'h00;
    pre_lock <= 1'b0;
    master_grant <= 8'h00;
  end else begin
    state <= next_state;
    if ((state == ST_IDLE || state == ST_POST) && next_state == ST_BUSY) begin
      owner <= pick;
      last_owner <= pick;
      master_grant <= 8'h01 << pick;
    end else if (state == ST_BUSY && next_state != ST_BUSY) begin
      master_grant <= 8'h00;
    end
    hold_count <= next_hold_count;
    pre_lock <= next_pre_lock;
    wait_count <= next_wait_count;
  end
end

////////////////////////////////////////////////////////////////////////////////
// idle counter and power saving
// counting in units of 16 clocks keeps the main counter at 24 bits
reg [3:0] unit_count;
reg [23:0] idle_units;
reg [3:0] next_unit_count;
reg [23:0] next_idle_units;
reg next_power_save;
reg [7:0] next_entry_count;
wire any_req = |master_req;

// a grant in flight counts as busy even with no request left high
always @* begin
  next_unit_count = unit_count;
  next_idle_units = idle_units;
  next_power_save = sdram_power_save;
  next_entry_count = self_refresh_entry_count;
  if (any_req || state != ST_IDLE || !sdram_powerdown_enable) begin
    next_unit_count = `SDARB_IDLE_UNIT;
    next_idle_units = 24'h00_0000;
    next_power_save = 1'b0;
  end else if (!sdram_power_save) begin
    next_unit_count = unit_count + 4'h1;
    if (unit_count == 4'hf) begin
      next_idle_units = idle_units + 24'h00_0001;
    end
    if (idle_units >= idle_target_count) begin
      next_power_save = 1'b1;
      next_entry_count = self_refresh_entry_count + 8'h01;
    end
  end
end

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    unit_count <= `SDARB_IDLE_UNIT;
    idle_units <= 24'h00_0000;
    sdram_power_save <= 1'b0;
    self_refresh_entry_count <= 8'h00;
    sdram_powerdown_enable_out <= 1'b0;
  end else begin
    sdram_powerdown_enable_out <= sdram_powerdown_enable;
    unit_count <= next_unit_count;
    idle_units <= next_idle_units;
    sdram_power_save <= next_power_save;
    self_refresh_entry_count <= next_entry_count;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read port
// reads are registered: data stands one cycle after the strobe, zero otherwise
wire [31:0] attr_word = {illegal_irq_pending, illegal_is_write, 10'h000,
  illegal_byte_lanes, 5'h00, illegal_initiator_code, illegal_size_bytes};
wire [31:0] pwr_word = {self_refresh_entry_count, idle_target_count};
wire [31:0] ctl_word = {3'h0, sdram_powerdown_enable, 28'h000_0000};

always @(posedge clock or negedge resetn) begin
  if (!resetn) begin
    reg_rdata <= 32'h0000_0000;
  end else if (reg_read) begin
    case (reg_addr)
      `SDARB_OFS_ARB_CFG: reg_rdata <= memory_arbiter_config;
      `SDARB_OFS_ILL_ADDR: reg_rdata <= illegal_access_address;
      `SDARB_OFS_ILL_ATTR: reg_rdata <= attr_word;
      `SDARB_OFS_PWR_SAVE: reg_rdata <= pwr_word;
      `SDARB_OFS_SDRAM_CTL: reg_rdata <= ctl_word;
      default: reg_rdata <= 32'h0000_0000;
    endcase
  end else begin
    reg_rdata <= 32'h0000_0000;
  end
end

endmodule // sdarb_top
`default_nettype wire

// ===== tb/sdarb_sva.sv
// concurrent checks on the sdram arbiter ports
`timescale 1ns/1ns
`default_nettype none
module sdarb_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0] master_req,
  input wire logic sdram_done,
  input wire logic [7:0] master_grant,
  input wire logic access_illegal,
  input wire logic illegal_irq,
  input wire logic sdram_power_save
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  sequence s_new_grant;
    master_grant != 8'h00 && $past(master_grant) == 8'h00;
  endsequence
  sequence s_clear;
    reg_write && reg_addr == 8'h14 && reg_wdata[31] && !access_illegal;
  endsequence
  a_grant_one_hot: assert property ($onehot0(master_grant))
    else $error("grant not one-hot");
  a_grant_has_req: assert property (
    s_new_grant |-> (master_grant & $past(master_req)) != 8'h00)
    else $error("grant without request");
  a_done_ends_grant: assert property (
    sdram_done && master_grant[7:1] != 7'h00 |=> master_grant == 8'h00)
    else $error("dma grant kept after done");
  a_irq_follows: assert property (access_illegal |-> ##2 illegal_irq)
    else $error("no interrupt after illegal access");
  a_irq_has_cause: assert property ($rose(illegal_irq) |-> $past(access_illegal, 2))
    else $error("interrupt without illegal access");
  a_clear_drops_irq: assert property (s_clear |-> ##2 !illegal_irq)
    else $error("interrupt kept after clear");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_access_wakes: assert property (master_req != 8'h00 |-> ##[1:2] !sdram_power_save)
    else $error("power saving kept during access");
endmodule // sdarb_sva
bind sdarb_top sdarb_sva sdarb_sva_i (.*);
`default_nettype wire

// ===== tb/sdarb_masters.sv
// bus masters that request the sdram and finish each granted transfer
`timescale 1ns/1ns
`default_nettype none
module sdarb_masters (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] want,
  input wire logic [7:0] master_grant,
  output logic [7:0] master_req,
  output logic sdram_done
);
  logic [7:0] held;
  logic [1:0] busy;
  logic sent;
  ////////////////////////////////////////
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      master_req <= 8'h00;
      sdram_done <= 1'b0;
      held <= 8'h00;
      busy <= 2'h0;
      sent <= 1'b0;
    end else begin
      sdram_done <= 1'b0;
      if (master_grant == 8'h00) begin
        // request held until its transfer is done, so no new grant sees an empty request
        master_req <= (master_req & ~held) | want;
        held <= 8'h00;
        busy <= 2'h0;
        sent <= 1'b0;
      end else begin
        held <= master_grant;
        busy <= busy + 2'h1;
        if (busy == 2'h2 && !sent) begin
          // the request falls with done so the arbiter cannot grant it twice
          master_req <= (master_req & ~master_grant) | want;
          sdram_done <= 1'b1;
          sent <= 1'b1;
        end else begin
          master_req <= master_req | want;
        end
      end
    end
  end
endmodule // sdarb_masters
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the sdram arbiter block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00, want = 8'h00, access_size = 8'h00, master_req, master_grant;
  logic [31:0] reg_wdata = 32'h0000_0000, access_addr = 32'h0000_0000, reg_rdata, rv;
  logic reg_write = 1'b0, reg_read = 1'b0, cpu_cmd_seen = 1'b0, access_illegal = 1'b0;
  logic access_is_write = 1'b0, sdram_done, illegal_irq, sdram_power_save;
  logic sdram_powerdown_enable_out, gnt;
  logic [3:0] access_byte_lanes = 4'h0;
  logic [2:0] access_initiator = 3'h0;
  int miscompares = 0, checks_done = 0, n;
  assign gnt = master_grant != 8'h00;
  sdarb_top sdarb_top_i (.*);
  sdarb_masters sdarb_masters_i (.*);
  initial forever #50 clock = ~clock;
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic ask(input logic [7:0] w, input logic cmd);
    @(posedge clock);
    want <= w;
    cpu_cmd_seen <= cmd;
    @(posedge clock);
    want <= 8'h00;
    cpu_cmd_seen <= 1'b0;
  endtask
  // bounded wait; n tells the cycles spent
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v) begin
      @(posedge clock);
      #1 n++;
      if (n == 200) begin
        miscompares++;
        give_verdict();
      end
    end
  endtask
  task automatic t_arb();
    rd(8'h1c);
    chk("idle target reset", 32'h0003_ffff, rv);
    ask(8'h03, 1'b0);
    wait_for(gnt, 1'b1);
    chk("fixed order", 8'h01, master_grant);
    wait_for(gnt, 1'b0);
    wait_for(gnt, 1'b1);
    wait_for(gnt, 1'b0);
    wr(8'h08, 32'h4000_0000);
    ask(8'h01, 1'b0);
    wait_for(gnt, 1'b1);
    wait_for(gnt, 1'b0);
    ask(8'h03, 1'b0);
    wait_for(gnt, 1'b1);
    chk("rotating order", 8'h02, master_grant);
    wait_for(gnt, 1'b0);
    wait_for(gnt, 1'b1);
    wait_for(gnt, 1'b0);
    $display("arbiter test done");
  endtask
  task automatic t_lock(input logic [31:0] cfg, input logic held_off);
    wr(8'h08, cfg);
    ask(8'h02, 1'b1);
    wait_for(gnt, 1'b1);
    chk("dma held by lock", {31'h0, held_off}, {31'h0, n >= 3});
    wait_for(gnt, 1'b0);
    $display("lock test done");
  endtask
  task automatic t_post(input logic [31:0] cfg, input logic held_off);
    wr(8'h08, cfg);
    ask(8'h01, 1'b0);
    wait_for(gnt, 1'b1);
    wait_for(gnt, 1'b0);
    ask(8'h02, 1'b0);
    wait_for(gnt, 1'b1);
    chk("dma held after cpu", {31'h0, held_off}, {31'h0, n >= 3});
    wait_for(gnt, 1'b0);
    $display("post-lock test done");
  endtask
  task automatic t_ill(input logic [2:0] i);
    @(posedge clock);
    access_illegal <= 1'b1;
    access_addr <= 32'h00c0_ffe0 | i;
    access_is_write <= i[0];
    access_byte_lanes <= {1'b1, i};
    access_initiator <= i;
    access_size <= 8'h04 + i;
    @(posedge clock);
    access_illegal <= 1'b0;
    rd(8'h10);
    chk("captured address", 32'h00c0_ffe0 | i, rv);
    rd(8'h14);
    chk("attributes", {1'b1, i[0], 10'h0, 1'b1, i, 5'h0, i, 8'h04 + i}, rv);
    chk("interrupt", 32'h1, {31'h0, illegal_irq});
    wr(8'h10, 32'hffff_ffff);
    rd(8'h14);
    chk("fields zeroed", 32'h0000_0000, rv & 32'h7fff_ffff);
    wr(8'h14, 32'h8000_0000);
    rd(8'h10);
    chk("address cleared", 32'h0000_0000, rv);
    chk("interrupt cleared", 32'h0, {31'h0, illegal_irq});
  endtask
  task automatic t_pwr();
    wr(8'h1c, 32'h0000_0002);
    repeat (60) @(posedge clock);
    chk("no saving while disabled", 32'h0, {31'h0, sdram_power_save});
    wr(8'h04, 32'h1000_0000);
    wait_for(sdram_power_save, 1'b1);
    // two units of sixteen idle cycles, plus register latency
    chk("idle entry time", 32'h1, {31'h0, n >= 31 && n <= 36});
    chk("powerdown enable", 32'h1, {31'h0, sdram_powerdown_enable_out});
    rd(8'h1c);
    chk("entry count", 32'h0100_0002, rv);
    ask(8'h02, 1'b0);
    wait_for(gnt, 1'b1);
    chk("left saving", 32'h0, {31'h0, sdram_power_save});
    $display("power test done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_arb();
    t_lock(32'h1000_0300, 1'b1);
    t_lock(32'h1000_0000, 1'b0);
    t_post(32'h2000_ff08, 1'b1);
    t_post(32'h2000_0008, 1'b0);
    t_post(32'h2000_ff00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      t_ill(3'(i));
    end
    $display("capture test done");
    t_pwr();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
